/* design/mfs_evt_if.sv */
// Interface carrying classified fault events between block modules
`timescale 1ns/1ns
interface mfs_evt_if;
  // One-cycle pulses, one per violation kind
  logic stack_viol;
  logic unstack_viol;
  logic data_viol;
  logic fetch_viol;
  // Address of the access and PC of the faulting instruction
  logic [31:0] viol_addr;
  logic [31:0] viol_pc;

  modport src (
    output stack_viol, unstack_viol, data_viol, fetch_viol,
    output viol_addr, viol_pc
  );
  modport sink (
    input stack_viol, unstack_viol, data_viol, fetch_viol,
    input viol_addr, viol_pc
  );
endinterface : mfs_evt_if

/* design/mfs_fault_detect.sv */
// Classifier that turns core access checks into violation pulses
`timescale 1ns/1ns
module mfs_fault_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic mpu_en,
  // Core access checks
  input wire logic stack_fault,
  input wire logic unstack_fault,
  input wire logic ls_req,
  input wire logic ls_write,
  input wire logic ls_perm_rd,
  input wire logic ls_perm_wr,
  input wire logic [31:0] ls_addr,
  input wire logic fetch_req,
  input wire logic fetch_xn,
  input wire logic fetch_perm_x,
  input wire logic [31:0] pc,
  // Classified events
  mfs_evt_if.src evt
);

  // ----------------------------------------
  // Registered classification
  // ----------------------------------------
  // Permission checks only apply with protection on
  always_ff @(posedge clk) begin
    if (rst) begin
      evt.stack_viol <= 1'b0;
      evt.unstack_viol <= 1'b0;
      evt.data_viol <= 1'b0;
      evt.fetch_viol <= 1'b0;
      evt.viol_addr <= 32'h0000_0000;
      evt.viol_pc <= 32'h0000_0000;
    end else begin
      evt.stack_viol <= stack_fault;
      evt.unstack_viol <= unstack_fault;
      evt.data_viol <= ls_req & mpu_en &
        (ls_write ? ~ls_perm_wr : ~ls_perm_rd);
      // Never-execute regions fault whatever the protection state
      evt.fetch_viol <= fetch_req &
        (fetch_xn | (mpu_en & ~fetch_perm_x));
      evt.viol_addr <= ls_addr;
      evt.viol_pc <= pc;
    end
  end

endmodule : mfs_fault_detect

/* design/mfs_frame_ctrl.sv */
// Exception frame directives for the core after a violation
`timescale 1ns/1ns
module mfs_frame_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Classified events
  mfs_evt_if.sink evt,
  // Frame directives, registered
  output logic frame_valid,
  output logic frame_sp_adjust,
  output logic frame_save,
  output logic frame_chain,
  output logic [31:0] frame_pc
);

  // ----------------------------------------
  // Directive register
  // ----------------------------------------
  // Unstack fault chains: keep old frame, no new save, SP left alone
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame_sp_adjust <= 1'b0;
      frame_save <= 1'b0;
      frame_chain <= 1'b0;
      frame_pc <= 32'h0000_0000;
    end else begin
      frame_valid <= evt.stack_viol | evt.unstack_viol |
        evt.data_viol | evt.fetch_viol;
      if (evt.unstack_viol) begin
        frame_sp_adjust <= 1'b0;
        frame_save <= 1'b0;
        frame_chain <= 1'b1;
      end else begin
        frame_sp_adjust <= 1'b1;
        frame_save <= 1'b1;
        frame_chain <= 1'b0;
      end
      // Return PC names the faulting instruction
      frame_pc <= evt.viol_pc;
    end
  end

endmodule : mfs_frame_ctrl

/* design/mfs_pkg.sv */
// Package of constants for the memory fault status byte block
package mfs_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h00C;
  localparam logic [11:0] OFF_IRQ_EN = 12'h010;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h014;

  // ----------------------------------------
  // Status byte and control field positions
  // ----------------------------------------
  localparam int BIT_FETCH = 0;
  localparam int BIT_DATA = 1;
  localparam int BIT_UNSTACK = 3;
  localparam int BIT_STACK = 4;
  localparam int BIT_ADDR_VALID = 7;
  localparam int BIT_MPU_EN = 0;

  // Implemented bits; 6:5 and 2 are reserved and read zero
  localparam logic [7:0] STATUS_MASK = 8'h9B;
  localparam logic [7:0] EVENT_MASK = 8'h1B;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [0:0] CTRL_RESET = 1'h0;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mfs_pkg

/* design/mfs_status_top.sv */
// Memory fault status byte with AXI4-Lite register access
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module mfs_status_top #(
  parameter int ADDR_W = mfs_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Core stacking checks
  input wire logic CORE_STACK_FAULT,
  input wire logic CORE_UNSTACK_FAULT,
  // Core load/store checks
  input wire logic CORE_LS_REQ,
  input wire logic CORE_LS_WRITE,
  input wire logic CORE_LS_PERM_RD,
  input wire logic CORE_LS_PERM_WR,
  input wire logic [31:0] CORE_LS_ADDR,
  // Core fetch checks
  input wire logic CORE_FETCH_REQ,
  input wire logic CORE_FETCH_XN,
  input wire logic CORE_FETCH_PERM_X,
  input wire logic [31:0] CORE_PC,
  // Frame directives to the core
  output logic FRAME_VALID,
  output logic FRAME_SP_ADJUST,
  output logic FRAME_SAVE,
  output logic FRAME_CHAIN,
  output logic [31:0] FRAME_PC,
  // Status view and interrupt
  output logic [7:0] FAULT_STATUS,
  output logic IRQ
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Register map needs at least five address bits
  generate
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("mfs_status_top: ADDR_W out of range");
    end
  endgenerate

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  // Word index match on the low address bits
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [11:0] off
  );
    logic [31:0] a32;
    a32 = 32'h0000_0000;
    a32[ADDR_W-1:0] = a; // Zero-extend so a five-bit bus needs no empty slice
    hit = (a32[4:2] == off[4:2]) && (a32[31:5] == 27'h000_0000);
  endfunction : hit

  // Known register for a given access direction
  function automatic logic mapped(
    input logic [ADDR_W-1:0] a,
    input logic is_wr
  );
    mapped = hit(a, mfs_pkg::OFF_STATUS) ||
      hit(a, mfs_pkg::OFF_CTRL) ||
      hit(a, mfs_pkg::OFF_IRQ_EN) ||
      (is_wr ? hit(a, mfs_pkg::OFF_IRQ_CLR)
             : (hit(a, mfs_pkg::OFF_ADDR) ||
                hit(a, mfs_pkg::OFF_IRQ_STAT)));
  endfunction : mapped

  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  logic [7:0] status;
  logic [7:0] next_status;
  logic [31:0] fault_addr_capture;
  logic mpu_en;
  logic [7:0] irq_stat;
  logic [7:0] next_irq_stat;
  logic [7:0] irq_en;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic [7:0] evt_bits;
  logic [7:0] st_clr;
  logic [7:0] irq_clr;

  mfs_evt_if evt ();

  // ----------------------------------------
  // Fault classification
  // ----------------------------------------
  mfs_fault_detect u_detect (
    .clk (SYS_CLK),
    .rst (SYS_RST),
    .mpu_en (mpu_en),
    .stack_fault (CORE_STACK_FAULT),
    .unstack_fault (CORE_UNSTACK_FAULT),
    .ls_req (CORE_LS_REQ),
    .ls_write (CORE_LS_WRITE),
    .ls_perm_rd (CORE_LS_PERM_RD),
    .ls_perm_wr (CORE_LS_PERM_WR),
    .ls_addr (CORE_LS_ADDR),
    .fetch_req (CORE_FETCH_REQ),
    .fetch_xn (CORE_FETCH_XN),
    .fetch_perm_x (CORE_FETCH_PERM_X),
    .pc (CORE_PC),
    .evt (evt.src)
  );

  // ----------------------------------------
  // Frame directives
  // ----------------------------------------
  mfs_frame_ctrl u_frame (
    .clk (SYS_CLK),
    .rst (SYS_RST),
    .evt (evt.sink),
    .frame_valid (FRAME_VALID),
    .frame_sp_adjust (FRAME_SP_ADJUST),
    .frame_save (FRAME_SAVE),
    .frame_chain (FRAME_CHAIN),
    .frame_pc (FRAME_PC)
  );

  // ----------------------------------------
  // AXI write channels
  // ----------------------------------------
  // Address and data may arrive in either order
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data holding stage
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Ready only while the holding slot is empty
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_held & ~S_AXI_BVALID &
        ~(S_AXI_AWVALID & S_AXI_AWREADY);
      S_AXI_WREADY <= ~w_held & ~S_AXI_BVALID &
        ~(S_AXI_WVALID & S_AXI_WREADY);
    end
  end

  assign do_write = aw_held & w_held & ~S_AXI_BVALID;

  // Response after both halves are in
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= mfs_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= mapped(aw_addr, 1'b1) ?
        mfs_pkg::RESP_OKAY : mfs_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write strobes to registers
  // ----------------------------------------
  // Only byte lane 0 carries flag bits
  always_comb begin
    st_clr = 8'h00;
    irq_clr = 8'h00;
    if (do_write && w_strb[0]) begin
      if (hit(aw_addr, mfs_pkg::OFF_STATUS)) begin
        st_clr = w_data[7:0] & mfs_pkg::STATUS_MASK;
      end else if (hit(aw_addr, mfs_pkg::OFF_IRQ_CLR)) begin
        irq_clr = w_data[7:0] & mfs_pkg::EVENT_MASK;
      end
    end
  end

  // ----------------------------------------
  // Control and interrupt enable
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mpu_en <= mfs_pkg::CTRL_RESET[0];
      irq_en <= mfs_pkg::IRQ_EN_RESET;
    end else if (do_write && w_strb[0]) begin
      if (hit(aw_addr, mfs_pkg::OFF_CTRL)) begin
        mpu_en <= w_data[mfs_pkg::BIT_MPU_EN];
      end else if (hit(aw_addr, mfs_pkg::OFF_IRQ_EN)) begin
        irq_en <= w_data[7:0] & mfs_pkg::EVENT_MASK;
      end
    end
  end

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  // Hardware set beats a same-cycle software clear
  always_comb begin
    evt_bits = 8'h00;
    evt_bits[mfs_pkg::BIT_STACK] = evt.stack_viol;
    evt_bits[mfs_pkg::BIT_UNSTACK] = evt.unstack_viol;
    evt_bits[mfs_pkg::BIT_DATA] = evt.data_viol;
    evt_bits[mfs_pkg::BIT_FETCH] = evt.fetch_viol;
    // Only a data fault loads an address, so only it validates
    evt_bits[mfs_pkg::BIT_ADDR_VALID] = evt.data_viol;
    next_status = ((status & ~st_clr) | evt_bits) &
      mfs_pkg::STATUS_MASK;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      status <= mfs_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // ----------------------------------------
  // Fault address capture
  // ----------------------------------------
  // Stack, unstack and fetch faults leave the address alone
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      fault_addr_capture <= mfs_pkg::ADDR_RESET;
    end else if (evt.data_viol) begin
      fault_addr_capture <= evt.viol_addr;
    end
  end

  // ----------------------------------------
  // Interrupt status and line
  // ----------------------------------------
  always_comb begin
    next_irq_stat = ((irq_stat & ~irq_clr) |
      (evt_bits & mfs_pkg::EVENT_MASK));
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_stat <= 8'h00;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Registered so the line follows the next-cycle state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
      FAULT_STATUS <= mfs_pkg::STATUS_RESET;
    end else begin
      IRQ <= |(next_irq_stat & irq_en);
      FAULT_STATUS <= next_status;
    end
  end

  // ----------------------------------------
  // AXI read channel
  // ----------------------------------------
  // One read at a time; address taken only while idle
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID &
        ~(S_AXI_ARVALID & S_AXI_ARREADY);
    end
  end

  // Read data mux; reserved bits and upper lanes return zero, except for the full-width fault address
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= mfs_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= mapped(S_AXI_ARADDR, 1'b0) ?
        mfs_pkg::RESP_OKAY : mfs_pkg::RESP_SLVERR;
      if (hit(S_AXI_ARADDR, mfs_pkg::OFF_STATUS)) begin
        S_AXI_RDATA <= {24'h00_0000, status};
      end else if (hit(S_AXI_ARADDR, mfs_pkg::OFF_ADDR)) begin
        S_AXI_RDATA <= fault_addr_capture;
      end else if (hit(S_AXI_ARADDR, mfs_pkg::OFF_CTRL)) begin
        S_AXI_RDATA <= {31'h0000_0000, mpu_en};
      end else if (hit(S_AXI_ARADDR, mfs_pkg::OFF_IRQ_STAT)) begin
        S_AXI_RDATA <= {24'h00_0000, irq_stat};
      end else if (hit(S_AXI_ARADDR, mfs_pkg::OFF_IRQ_EN)) begin
        S_AXI_RDATA <= {24'h00_0000, irq_en};
      end else begin
        S_AXI_RDATA <= 32'h0000_0000;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Address-valid clear by the hard fault handler is a status W1C of bit 7

endmodule : mfs_status_top

/* testbench/mfs_core_model.sv */
// Behavioural core model that reports access checks to the block
`timescale 1ns/1ns
module mfs_core_model (
  // Command from the bench
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [31:0] addr,
  // Access checks toward the block
  output logic stack_fault,
  output logic unstack_fault,
  output logic ls_req,
  output logic ls_write,
  output logic perm_rd,
  output logic perm_wr,
  output logic [31:0] ls_addr,
  output logic fetch_req,
  output logic fetch_xn,
  output logic perm_x,
  output logic [31:0] pc
);
  // Kinds: 0 stack, 1 unstack, 2 load denied, 3 store denied,
  // 4 never-execute fetch, 5 fetch without permission, 6 permitted load
  always_comb begin
    stack_fault = go && kind == 3'h0;
    unstack_fault = go && kind == 3'h1;
    ls_req = go && (kind == 3'h2 || kind == 3'h3 || kind == 3'h6);
    ls_write = kind == 3'h3;
    perm_rd = kind != 3'h2;
    perm_wr = kind != 3'h3;
    fetch_req = go && (kind == 3'h4 || kind == 3'h5);
    fetch_xn = kind == 3'h4;
    perm_x = kind != 3'h5;
  end
  // Idle address is inverted so a stale capture would show
  assign ls_addr = ls_req ? addr : ~addr;
  assign pc = addr ^ 32'h0000_0FF0;
endmodule : mfs_core_model

/* testbench/mfs_monitor.sv */
// Checker for the memory fault status byte, bound to the top module
`timescale 1ns/1ns
module mfs_monitor (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Observed ports
  input wire logic S_AXI_BVALID,
  input wire logic CORE_STACK_FAULT,
  input wire logic CORE_UNSTACK_FAULT,
  input wire logic CORE_LS_REQ,
  input wire logic CORE_FETCH_REQ,
  input wire logic CORE_FETCH_XN,
  input wire logic [31:0] CORE_PC,
  input wire logic FRAME_VALID,
  input wire logic FRAME_SP_ADJUST,
  input wire logic FRAME_SAVE,
  input wire logic FRAME_CHAIN,
  input wire logic [31:0] FRAME_PC,
  input wire logic [7:0] FAULT_STATUS
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Frame directives land two edges after the core reports
  sequence s_stack_frame;
    ##2 FRAME_VALID && FRAME_SP_ADJUST && FRAME_SAVE && !FRAME_CHAIN;
  endsequence
  sequence s_unstack_frame;
    ##2 FRAME_VALID && FRAME_CHAIN && !FRAME_SP_ADJUST && !FRAME_SAVE;
  endsequence
  AST_RSV_ZERO: assert property (FAULT_STATUS[6:5] == 2'h0 && !FAULT_STATUS[2])
    else $error("reserved status bit is set");
  AST_STACK: assert property (CORE_STACK_FAULT |-> s_stack_frame ##0 FAULT_STATUS[4])
    else $error("stacking fault frame or flag missing");
  AST_STACK_CAUSE: assert property ($rose(FAULT_STATUS[4]) |-> $past(CORE_STACK_FAULT, 2))
    else $error("stacking flag rose without a stacking fault");
  AST_UNSTACK: assert property (CORE_UNSTACK_FAULT |-> s_unstack_frame ##0 FAULT_STATUS[3])
    else $error("unstacking fault frame or flag missing");
  AST_FETCH: assert property (CORE_FETCH_REQ && CORE_FETCH_XN
    |-> ##2 FAULT_STATUS[0] && FRAME_PC == $past(CORE_PC, 2))
    else $error("never-execute fetch not flagged");
  AST_DATA_VALID: assert property ($rose(FAULT_STATUS[1]) |-> FAULT_STATUS[7])
    else $error("data fault without address-valid");
  AST_DATA_PC: assert property ($rose(FAULT_STATUS[1])
    |-> FRAME_PC == $past(CORE_PC, 2))
    else $error("data fault frame PC is not the faulting instruction");
  AST_ADDR_CAUSE: assert property ($rose(FAULT_STATUS[7]) |-> $past(CORE_LS_REQ, 2))
    else $error("address-valid rose without a load or store");
  AST_NO_SELF_CLEAR: assert property ((($past(FAULT_STATUS) & ~FAULT_STATUS) != 8'h00)
    |-> S_AXI_BVALID || $past(S_AXI_BVALID) || $past(SYS_RST))
    else $error("status flag cleared without a write");
endmodule : mfs_monitor

bind mfs_status_top mfs_monitor mon_u (.SYS_CLK, .SYS_RST, .S_AXI_BVALID, .CORE_STACK_FAULT,
  .CORE_UNSTACK_FAULT, .CORE_LS_REQ, .CORE_FETCH_REQ, .CORE_FETCH_XN, .CORE_PC, .FRAME_VALID,
  .FRAME_SP_ADJUST, .FRAME_SAVE, .FRAME_CHAIN, .FRAME_PC, .FAULT_STATUS);

/* testbench/testbench.sv */
// Self-checking bench for the memory fault status byte
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awa = '0;
  logic [11:0] ara = '0;
  logic [31:0] wd = '0;
  logic [31:0] ea = '0;
  logic [31:0] cap = '0;
  logic [3:0] ws = 4'hF;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, go = 1'b0;
  logic [2:0] kind = '0;
  logic awrdy, wrdy, bv, arrdy, rv, irq, cs, cu, cl, clw, cpr, cpw, cf, cx, cpx;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, cla, cpc, d;
  logic [7:0] fst;
  // Row: kind in 14:12, protection enable in 8, expected status in 7:0
  logic [15:0] rows [10];
  logic [7:0] clr_w [4];
  logic [7:0] clr_e [4];
  int err_total = 0;
  int total_checks = 0;

  mfs_status_top dut_u (.SYS_CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .CORE_STACK_FAULT(cs), .CORE_UNSTACK_FAULT(cu), .CORE_LS_REQ(cl), .CORE_LS_WRITE(clw),
    .CORE_LS_PERM_RD(cpr), .CORE_LS_PERM_WR(cpw), .CORE_LS_ADDR(cla), .CORE_FETCH_REQ(cf),
    .CORE_FETCH_XN(cx), .CORE_FETCH_PERM_X(cpx), .CORE_PC(cpc), .FRAME_VALID(),
    .FRAME_SP_ADJUST(), .FRAME_SAVE(), .FRAME_CHAIN(), .FRAME_PC(), .FAULT_STATUS(fst), .IRQ(irq));

  mfs_core_model core_u (.go(go), .kind(kind), .addr(ea), .stack_fault(cs), .unstack_fault(cu),
    .ls_req(cl), .ls_write(clw), .perm_rd(cpr), .perm_wr(cpw), .ls_addr(cla), .fetch_req(cf),
    .fetch_xn(cx), .perm_x(cpx), .pc(cpc));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A bus wait that runs out ends the run
  task automatic waited(input int n);
    if (n >= 100) begin
      err_total++;
      $display("ERROR at %0t: bus answer never came", $time);
      results();
    end
  endtask : waited

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) br <= 1'b0;
    end while (!bv && n < 100);
    waited(n);
    chk({30'd0, bresp}, {30'd0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arrdy) arv <= 1'b0;
      if (rv) rr <= 1'b0;
    end while (!rv && n < 100);
    waited(n);
    v = rdata;
    chk({30'd0, rresp}, {30'd0, er});
  endtask : rd

  // One-cycle core report; the status shows two edges later
  task automatic fire(input logic [2:0] k, input logic [31:0] a);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    ea <= a;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : fire

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{16'h0010, 16'h1008, 16'h2182, 16'h3182, 16'h2000,
             16'h4001, 16'h4101, 16'h5101, 16'h5000, 16'h6100};
    clr_w = '{8'h64, 8'h10, 8'h00, 8'h80};
    clr_e = '{8'h92, 8'h82, 8'h82, 8'h02};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then refused places
    rd(mfs_pkg::OFF_STATUS, mfs_pkg::RESP_OKAY, d);
    chk(d, 32'h0000_0000);
    rd(mfs_pkg::OFF_CTRL, mfs_pkg::RESP_OKAY, d);
    chk(d, 32'h0000_0000);
    rd(12'h020, mfs_pkg::RESP_SLVERR, d);
    chk(d, 32'h0000_0000);
    wr(mfs_pkg::OFF_ADDR, 32'h0000_0001, mfs_pkg::RESP_SLVERR);
    wr(mfs_pkg::OFF_IRQ_EN, 32'h0000_001B, mfs_pkg::RESP_OKAY);
    // Every kind of report; kinds 2, 4 and 5 both with and without protection enabled
    for (int i = 0; i < 10; i++) begin
      wr(mfs_pkg::OFF_CTRL, {31'd0, rows[i][8]}, mfs_pkg::RESP_OKAY);
      fire(rows[i][14:12], 32'h2000_0100 + 32'(i));
      rd(mfs_pkg::OFF_STATUS, mfs_pkg::RESP_OKAY, d);
      chk(d, {24'd0, rows[i][7:0]});
      chk({24'd0, fst}, {24'd0, rows[i][7:0]});
      chk({31'd0, irq}, {31'd0, |(rows[i][7:0] & 8'h1B)});
      // Only a data fault moves the capture; other faults leave it alone
      if (rows[i][1]) begin
        cap = 32'h2000_0100 + 32'(i);
      end
      rd(mfs_pkg::OFF_ADDR, mfs_pkg::RESP_OKAY, d);
      chk(d, cap);
      wr(mfs_pkg::OFF_STATUS, 32'h0000_00FF, mfs_pkg::RESP_OKAY);
      wr(mfs_pkg::OFF_IRQ_CLR, 32'h0000_00FF, mfs_pkg::RESP_OKAY);
      rd(mfs_pkg::OFF_STATUS, mfs_pkg::RESP_OKAY, d);
      chk(d, 32'h0000_0000);
      chk({31'd0, irq}, 32'h0000_0000);
    end
    // Back-to-back stacking and data reports, then clearing one flag at a time
    @(posedge clk);
    go <= 1'b1;
    kind <= 3'h0;
    ea <= 32'h3000_0040;
    @(posedge clk);
    kind <= 3'h2;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    chk({24'd0, fst}, 32'h0000_0092);
    rd(mfs_pkg::OFF_ADDR, mfs_pkg::RESP_OKAY, d);
    chk(d, 32'h3000_0040);
    // Lane 0 strobe low: answered, but clears nothing (first row below sees 0x92)
    ws <= 4'hE;
    wr(mfs_pkg::OFF_STATUS, 32'h0000_00FF, mfs_pkg::RESP_OKAY);
    ws <= 4'hF;
    for (int j = 0; j < 4; j++) begin
      wr(mfs_pkg::OFF_STATUS, {24'd0, clr_w[j]}, mfs_pkg::RESP_OKAY);
      rd(mfs_pkg::OFF_STATUS, mfs_pkg::RESP_OKAY, d);
      chk(d, {24'd0, clr_e[j]});
    end
    // Masked interrupt stays low while the flag is set
    wr(mfs_pkg::OFF_IRQ_EN, 32'h0000_0000, mfs_pkg::RESP_OKAY);
    fire(3'h0, 32'h0000_0000);
    chk({31'd0, irq}, 32'h0000_0000);
    chk({24'd0, fst}, 32'h0000_0012);
    // Status clears leave the separate interrupt status standing
    rd(mfs_pkg::OFF_IRQ_STAT, mfs_pkg::RESP_OKAY, d);
    chk(d, 32'h0000_0012);
    // Enabling a pending source raises the line one edge after the write lands
    wr(mfs_pkg::OFF_IRQ_EN, 32'h0000_0010, mfs_pkg::RESP_OKAY);
    @(posedge clk);
    chk({31'd0, irq}, 32'h0000_0001);
    // Reset in mid-run clears every flag
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(mfs_pkg::OFF_STATUS, mfs_pkg::RESP_OKAY, d);
    chk(d, 32'h0000_0000);
    chk({24'd0, fst}, 32'h0000_0000);
    chk({31'd0, irq}, 32'h0000_0000);
    rd(mfs_pkg::OFF_ADDR, mfs_pkg::RESP_OKAY, d);
    chk(d, 32'h0000_0000);
    results();
  end
endmodule : testbench
